// ==== logic/emb_pkg.sv ====
// shared constants and types for the 16-bit external memory bus block
// assumes one 20 MHz core clock and a core that issues one access at a time
package emb_pkg;

  // register port offsets
  localparam logic [3:0] REG_MEM_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;

  // memory_bus_control field layout and reset value
  localparam int         BIT_EXT_BUS_DISABLE = 7;
  localparam int         WAIT_COUNT_LSB      = 4;
  localparam int         WRITE_MODE_LSB      = 0;
  localparam logic [7:0] MEM_CTRL_RESET      = 8'h00;
  localparam logic [7:0] MEM_CTRL_WRITABLE   = 8'hb3;

  // table_write_mode encodings; bit 1 set means word write
  localparam logic [1:0] WRITE_MODE_BYTE_WRITE  = 2'h0;
  localparam logic [1:0] WRITE_MODE_BYTE_SELECT = 2'h1;
  localparam int         WRITE_MODE_WORD_BIT    = 1;

  // timing: one instruction cycle is four clock periods
  localparam int         CLOCK_NS    = 50;
  localparam int         TCY_NS      = 200;
  localparam int         TCY_CYCLES  = (TCY_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [3:0] ADDR_CYCLES = 4'h2;
  localparam logic [3:0] DATA_CYCLES = 4'(TCY_CYCLES);

  typedef enum logic [1:0] {
    MODE_MICROPROCESSOR,
    MODE_BOOT_BLOCK,
    MODE_EXTENDED,
    MODE_MICROCONTROLLER
  } emb_mode_t;

  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_TABLE_READ,
    ACC_TABLE_WRITE
  } emb_kind_t;

  // one access from the core; address is a byte address
  typedef struct packed {
    emb_kind_t   kind;
    logic [20:0] addr;
    logic [7:0]  table_latch;
  } emb_req_t;

  // data phase plan for one access
  typedef struct packed {
    logic [15:0] data;
    logic        drive;
    logic        write_high_strobe_n;
    logic        write_low_strobe_n;
    logic        upper_byte_select_n;
    logic        lower_byte_select_n;
  } emb_lane_t;

endpackage

// ==== logic/emb_pin_sync.sv ====
// three-stage input synchroniser with agreement filter for bus pins
// assumes the pins are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module emb_pin_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // pins in, filtered value out
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change only counts once the last two stages agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value <= '0;
    end else if (stage2 == stage3) begin
      value <= stage3;
    end
  end

endmodule
`default_nettype wire

// ==== logic/emb_lane_plan.sv ====
// data lanes and write strobes for the data phase of one access
// assumes the main sequencer registers the result before it reaches pins
`timescale 1ns/1ps
`default_nettype none
module emb_lane_plan (
  // access description
  input  wire logic [1:0]        table_write_mode,
  input  wire emb_pkg::emb_kind_t kind,
  input  wire logic              addr_lsb,
  input  wire logic [7:0]        table_latch,
  input  wire logic [7:0]        held_even_byte,
  // plan
  output var  emb_pkg::emb_lane_t plan
);

  always_comb begin
    plan.data                = {table_latch, table_latch};
    plan.drive               = 1'b1;
    plan.write_high_strobe_n = 1'b1;
    plan.write_low_strobe_n  = 1'b1;
    plan.upper_byte_select_n = 1'b0;
    plan.lower_byte_select_n = 1'b0;
    if (kind != emb_pkg::ACC_TABLE_WRITE) begin
      // reads return both bytes as one word
      plan.drive = 1'b0;
    end else if (table_write_mode[emb_pkg::WRITE_MODE_WORD_BIT]) begin
      if (!addr_lsb) begin
        plan.drive = 1'b0;
      end else begin
        plan.data                = {table_latch, held_even_byte};
        plan.write_high_strobe_n = 1'b0;
      end
    end else if (table_write_mode == emb_pkg::WRITE_MODE_BYTE_SELECT) begin
      plan.write_high_strobe_n = 1'b0;
      plan.upper_byte_select_n = !addr_lsb;
      plan.lower_byte_select_n = addr_lsb;
    end else if (addr_lsb) begin
      plan.write_high_strobe_n = 1'b0;
    end else begin
      plan.write_low_strobe_n = 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== logic/emb_bus.sv ====
// external memory bus sequencer with its control register
// assumes core strobes, sleep and execution flags are on clock; ad pins are asynchronous
//
// Overview of operation
// - fully external mode keeps the bus active; pins never act as ports.
// - fully internal mode keeps pins as ports and refuses control register writes.
// - mixed modes switch pins to the bus for every external fetch or table access.
// - mixed modes, internal only: bus when disable bit is 0, ports when 1.
// - an external access while the disable bit is set still takes the bus.
// - setting the disable bit from external code waits until execution is internal.
// - idle bus: lines tri-stated, strobes and selects high, latch strobe and byte address low.
// - table cycles wait by field: 11 none, 10 one, 01 two, 00 three cycles.
// - write mode 1x is word write; high strobe fires when the odd byte is written.
// - write mode 01 copies latch on both bytes, high strobe plus one byte select.
// - write mode 00 copies latch on both bytes, high or low strobe.
// - disable bit resets to 0; when 1 in mixed modes all bus drivers return to ports.
// - only the 16-bit bus exists; software cannot change the width.
// - each access pulses the latch strobe with the address, reads then assert output enable.
// - chip enable is low for every external access and high in sleep.
// - byte write drives latch on both halves, strobe chosen by pointer bit 0.
// - word write even address: hold the latch, tri-state data, no strobe.
// - word write odd address: latch on upper byte, held byte on lower byte.
// - word write strobes only the high line, byte address shows bit 0, both selects low.
// - byte select drives latch on both bytes, high strobe, byte chosen from bit 0.
`timescale 1ns/1ps
`default_nettype none
module emb_bus (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               reset_n,
  // program memory mode strap, caught once after reset
  input  wire emb_pkg::emb_mode_t mode_strap,
  // core status
  input  wire logic               sleep,
  input  wire logic               exec_from_external,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output var  logic [7:0]         reg_rdata,
  // access requests from the core
  input  wire logic               req_valid,
  input  wire emb_pkg::emb_req_t  req,
  output var  logic               req_ready,
  output var  logic               resp_done,
  output var  logic [15:0]        resp_rdata,
  // pin ownership: high while the shared pins carry the bus function
  output var  logic               pins_are_bus,
  // address/data and upper address pins
  input  wire logic [15:0]        ad_in,
  output var  logic [15:0]        ad_out,
  output var  logic               ad_oe,
  output var  logic [3:0]         upper_addr_out,
  output var  logic               upper_addr_oe,
  // control pins
  output var  logic               address_latch_strobe,
  output var  logic               output_enable_n,
  output var  logic               chip_enable_n,
  output var  logic               write_high_strobe_n,
  output var  logic               write_low_strobe_n,
  output var  logic               upper_byte_select_n,
  output var  logic               lower_byte_select_n,
  output var  logic               byte_address_lsb
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_RECOVER
  } emb_state_t;

  emb_state_t         state;
  emb_pkg::emb_mode_t mode;
  logic               mode_caught;
  logic               external_bus_disable;
  logic               disable_in_force;
  logic [1:0]         wait_count;
  logic [1:0]         table_write_mode;
  emb_pkg::emb_req_t  cur;
  logic [7:0]         held_even_byte;
  logic [3:0]         cnt;
  logic [15:0]        ad_sampled;
  emb_pkg::emb_lane_t plan;
  logic               take;
  logic               can_accept;
  logic               ctrl_write;

  // last count of the data phase; only table cycles take wait states.
  // the last count, not the length, is returned so three waits still fit four bits
  function automatic logic [3:0] data_last(input emb_pkg::emb_kind_t kind,
                                           input logic [1:0] wait_sel);
    logic [1:0] short_by;
    logic [3:0] extra;
    short_by = ~wait_sel;
    extra    = 4'(short_by) * 4'(emb_pkg::TCY_CYCLES);
    if (kind == emb_pkg::ACC_FETCH) begin
      data_last = emb_pkg::DATA_CYCLES - 4'h1;
    end else begin
      data_last = emb_pkg::DATA_CYCLES - 4'h1 + extra;
    end
  endfunction

  function automatic logic is_mixed(input emb_pkg::emb_mode_t m);
    is_mixed = (m == emb_pkg::MODE_BOOT_BLOCK) || (m == emb_pkg::MODE_EXTENDED);
  endfunction

  // no access starts in sleep, so chip enable stays high there
  assign can_accept = mode_caught && (mode != emb_pkg::MODE_MICROCONTROLLER) && !sleep;
  assign take       = req_valid && req_ready && (state == ST_IDLE);
  // no width bit exists in the control register: the bus is 16 bits only
  assign ctrl_write = reg_write && (reg_addr == emb_pkg::REG_MEM_CTRL) &&
                      (mode != emb_pkg::MODE_MICROCONTROLLER);

  emb_pin_sync #(
    .WIDTH (16)
  ) u_ad_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pin_in  (ad_in),
    .value   (ad_sampled)
  );

  emb_lane_plan u_lane (
    .table_write_mode (table_write_mode),
    .kind             (cur.kind),
    .addr_lsb         (cur.addr[0]),
    .table_latch      (cur.table_latch),
    .held_even_byte   (held_even_byte),
    .plan             (plan)
  );

  // mode strap is caught on the first edge after reset release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode        <= emb_pkg::MODE_MICROCONTROLLER;
      mode_caught <= 1'b0;
    end else if (!mode_caught) begin
      mode        <= mode_strap;
      mode_caught <= 1'b1;
    end
  end

  // control register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      external_bus_disable <= emb_pkg::MEM_CTRL_RESET[emb_pkg::BIT_EXT_BUS_DISABLE];
      wait_count           <= emb_pkg::MEM_CTRL_RESET[emb_pkg::WAIT_COUNT_LSB +: 2];
      table_write_mode     <= emb_pkg::MEM_CTRL_RESET[emb_pkg::WRITE_MODE_LSB +: 2];
    end else if (ctrl_write) begin
      external_bus_disable <= reg_wdata[emb_pkg::BIT_EXT_BUS_DISABLE];
      wait_count           <= reg_wdata[emb_pkg::WAIT_COUNT_LSB +: 2];
      table_write_mode     <= reg_wdata[emb_pkg::WRITE_MODE_LSB +: 2];
    end
  end

  // clearing takes effect at once; setting waits for internal execution
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      disable_in_force <= 1'b0;
    end else if (!external_bus_disable) begin
      disable_in_force <= 1'b0;
    end else if (!exec_from_external) begin
      disable_in_force <= 1'b1;
    end
  end

  // read data stand for exactly one cycle after the read strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read && reg_addr == emb_pkg::REG_MEM_CTRL) begin
      reg_rdata <= {external_bus_disable, 1'b0, wait_count, 2'b00, table_write_mode}
                   & emb_pkg::MEM_CTRL_WRITABLE;
    end else if (reg_read && reg_addr == emb_pkg::REG_STATUS) begin
      reg_rdata <= {(state != ST_IDLE), pins_are_bus, disable_in_force, mode_caught,
                    2'b00, 2'(mode)};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // pin ownership
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pins_are_bus <= 1'b0;
    end else if (!mode_caught) begin
      pins_are_bus <= 1'b0;
    end else if (mode == emb_pkg::MODE_MICROPROCESSOR) begin
      pins_are_bus <= 1'b1;
    end else if (!is_mixed(mode)) begin
      pins_are_bus <= 1'b0;
    end else if (take || state != ST_IDLE) begin
      pins_are_bus <= 1'b1;
    end else begin
      pins_are_bus <= !disable_in_force;
    end
  end

  // access sequencer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
      cur   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take) begin
            cur   <= req;
            cnt   <= emb_pkg::ADDR_CYCLES - 4'h1;
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cnt == 4'h0) begin
            cnt   <= data_last(cur.kind, wait_count);
            state <= ST_DATA;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_DATA: begin
          if (cnt == 4'h0) begin
            state <= ST_RECOVER;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // even byte of a word write waits here for its odd partner
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      held_even_byte <= 8'h00;
    end else if (take && req.kind == emb_pkg::ACC_TABLE_WRITE && !req.addr[0] &&
                 table_write_mode[emb_pkg::WRITE_MODE_WORD_BIT]) begin
      held_even_byte <= req.table_latch;
    end
  end

  // core handshake
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_ready  <= 1'b0;
      resp_done  <= 1'b0;
      resp_rdata <= 16'h0000;
    end else begin
      req_ready <= can_accept && (state == ST_IDLE) && !take;
      // the pin filter lags four edges, so the word is only settled in recovery
      resp_done <= (state == ST_RECOVER);
      if (state == ST_RECOVER && cur.kind != emb_pkg::ACC_TABLE_WRITE) begin
        resp_rdata <= ad_sampled;
      end
    end
  end

  // address and data pins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ad_out         <= 16'h0000;
      ad_oe          <= 1'b0;
      upper_addr_out <= 4'h0;
      upper_addr_oe  <= 1'b0;
    end else if (take) begin
      ad_out         <= req.addr[16:1];
      ad_oe          <= 1'b1;
      upper_addr_out <= req.addr[20:17];
      upper_addr_oe  <= 1'b1;
    end else if (state == ST_ADDR && cnt == 4'h0) begin
      ad_out <= plan.data;
      ad_oe  <= plan.drive;
    end else if (state == ST_RECOVER) begin
      // data are held through recovery so the strobe edge sees them stable
      ad_out         <= 16'h0000;
      ad_oe          <= 1'b0;
      upper_addr_out <= 4'h0;
      upper_addr_oe  <= 1'b0;
    end
  end

  // control pins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      address_latch_strobe <= 1'b0;
      output_enable_n      <= 1'b1;
      chip_enable_n        <= 1'b1;
      write_high_strobe_n  <= 1'b1;
      write_low_strobe_n   <= 1'b1;
      upper_byte_select_n  <= 1'b1;
      lower_byte_select_n  <= 1'b1;
      byte_address_lsb     <= 1'b0;
    end else if (take) begin
      address_latch_strobe <= 1'b1;
      chip_enable_n        <= 1'b0;
      byte_address_lsb     <= req.addr[0];
    end else if (state == ST_ADDR && cnt == 4'h0) begin
      address_latch_strobe <= 1'b0;
      output_enable_n      <= (cur.kind == emb_pkg::ACC_TABLE_WRITE);
      write_high_strobe_n  <= plan.write_high_strobe_n;
      write_low_strobe_n   <= plan.write_low_strobe_n;
      upper_byte_select_n  <= plan.upper_byte_select_n;
      lower_byte_select_n  <= plan.lower_byte_select_n;
    end else if (state == ST_ADDR) begin
      address_latch_strobe <= 1'b0;
    end else if (state == ST_DATA && cnt == 4'h0) begin
      output_enable_n     <= 1'b1;
      write_high_strobe_n <= 1'b1;
      write_low_strobe_n  <= 1'b1;
    end else if (state == ST_RECOVER) begin
      chip_enable_n       <= 1'b1;
      upper_byte_select_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
      byte_address_lsb    <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== bench/emb_bus_assertions.sv ====
// checker for the external memory bus sequencer
// assumes it is bound to emb_bus and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module emb_bus_chk (
  // clock and reset
  input wire logic               clock,
  input wire logic               reset_n,
  // core side
  input wire emb_pkg::emb_mode_t mode_strap,
  input wire logic [3:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_write,
  input wire logic               req_valid,
  input wire emb_pkg::emb_req_t  req,
  input wire logic               req_ready,
  input wire logic               resp_done,
  input wire logic               pins_are_bus,
  // pins
  input wire logic [15:0]        ad_out,
  input wire logic               ad_oe,
  input wire logic               upper_addr_oe,
  input wire logic               address_latch_strobe,
  input wire logic               output_enable_n,
  input wire logic               chip_enable_n,
  input wire logic               write_high_strobe_n,
  input wire logic               write_low_strobe_n,
  input wire logic               upper_byte_select_n,
  input wire logic               lower_byte_select_n,
  input wire logic               byte_address_lsb
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] ctl;
  logic [4:0] cnt;
  logic [4:0] lat;
  logic [1:0] up;
  // mirror of control; refused writes only occur where no access follows
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ctl <= 8'h00;
    else if (reg_write && reg_addr == 4'h0) ctl <= reg_wdata;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 5'h00;
      lat <= 5'h00;
      up  <= 2'h0;
    end else begin
      if (up != 2'h2) up <= up + 2'h1;
      if (req_valid && req_ready) begin
        cnt <= 5'h01;
        lat <= (req.kind == emb_pkg::ACC_FETCH) ? 5'h08 : 5'h14 - {1'b0, ctl[5:4], 2'h0};
      end else if (resp_done) cnt <= 5'h00;
      else if (cnt != 5'h00) cnt <= cnt + 5'h01;
    end
  end
  AST_IDLE:
    assert property (chip_enable_n |-> !ad_oe && !upper_addr_oe && output_enable_n
      && write_high_strobe_n && write_low_strobe_n && upper_byte_select_n
      && lower_byte_select_n && !address_latch_strobe && !byte_address_lsb)
    else $error("idle pins not parked");
  AST_TAKE:
    assert property (req_valid && req_ready |=> address_latch_strobe && ad_oe
      && ad_out == $past(req.addr[16:1]) ##1 !address_latch_strobe)
    else $error("address phase wrong");
  AST_LAT:
    assert property (resp_done |-> cnt == lat) else $error("access length wrong");
  AST_READ:
    assert property (!output_enable_n |-> !ad_oe && !chip_enable_n && write_high_strobe_n
      && write_low_strobe_n) else $error("read phase wrong");
  AST_CE:
    assert property (!chip_enable_n |-> pins_are_bus) else $error("access off the bus");
  AST_MC:
    assert property (mode_strap == emb_pkg::MODE_MICROCONTROLLER |-> !pins_are_bus
      && !req_ready) else $error("internal mode used the bus");
  AST_MP:
    assert property (mode_strap == emb_pkg::MODE_MICROPROCESSOR && up == 2'h2
      |-> pins_are_bus) else $error("external mode left the bus");
  AST_BW:
    assert property (ctl[1:0] == 2'h0 && !(write_high_strobe_n && write_low_strobe_n)
      |-> write_high_strobe_n == !byte_address_lsb && write_low_strobe_n == byte_address_lsb
      && !upper_byte_select_n && !lower_byte_select_n) else $error("byte write strobes");
  AST_BS:
    assert property (ctl[1:0] == 2'h1 && !write_high_strobe_n |-> write_low_strobe_n
      && upper_byte_select_n == !byte_address_lsb && lower_byte_select_n == byte_address_lsb)
    else $error("byte select strobes");
  AST_WW:
    assert property (ctl[1] && !chip_enable_n |-> write_low_strobe_n
      && (write_high_strobe_n || byte_address_lsb)) else $error("word write strobes");
endmodule
bind emb_bus emb_bus_chk chk (.*);
`default_nettype wire

// ==== bench/emb_ext_mem.sv ====
// model of a word-wide external memory on the bus
// assumes the ad wire is resolved here; the lines have no pull
`timescale 1ns/1ps
`default_nettype none
module emb_ext_mem (
  // clock
  input  wire logic        clock,
  // bus pins from the block
  input  wire logic [15:0] ad_out,
  input  wire logic        ad_oe,
  input  wire logic [3:0]  upper_addr_out,
  input  wire logic        ale,
  input  wire logic        oe_n,
  input  wire logic        ce_n,
  input  wire logic        hi_n,
  input  wire logic        lo_n,
  input  wire logic        usel_n,
  input  wire logic        lsel_n,
  input  wire logic        ba,
  // resolved wire and the last write seen
  output var  logic [15:0] ad_in,
  output var  logic [15:0] wdata,
  output var  logic [4:0]  wstb,
  output var  logic [7:0]  nwr
);
  logic [19:0] addr;
  logic [15:0] last = 16'h0000;
  logic        drv;
  initial nwr = 8'h00;
  assign drv = !oe_n && !ce_n;
  // a released line shows the inverse of its last level, so no stale hold
  assign ad_in = ad_oe ? ad_out : drv ? addr[15:0] ^ {12'h000, addr[19:16]} ^ 16'h5a3c : ~last;
  always @(posedge clock) begin
    last <= ad_in;
    if (ale) addr <= {upper_addr_out, ad_out};
    if (!ce_n && !(hi_n && lo_n)) begin
      wdata <= ad_out;
      wstb  <= {hi_n, lo_n, usel_n, lsel_n, ba};
      nwr   <= nwr + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== bench/emb_bus_test.sv ====
// self-checking bench for the external memory bus sequencer
// assumes emb_bus, its checker and the memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module emb_bus_test;
  logic               clock = 1'b0, reset_n = 1'b0, sleep = 1'b0, exec_from_external = 1'b0;
  emb_pkg::emb_mode_t mode_strap = emb_pkg::MODE_MICROPROCESSOR;
  logic [3:0]         reg_addr = 4'h0;
  logic [7:0]         reg_wdata = 8'h00, reg_rdata, nwr;
  logic               reg_write = 1'b0, reg_read = 1'b0, req_valid = 1'b0;
  emb_pkg::emb_req_t  req = '0;
  logic               req_ready, resp_done, pins_are_bus, ad_oe, upper_addr_oe, ale, oe_n;
  logic               ce_n, hi_n, lo_n, usel_n, lsel_n, ba;
  logic [15:0]        resp_rdata, ad_in, ad_out, wdata;
  logic [3:0]         upper_addr_out;
  logic [4:0]         wstb;
  int                 fail_count = 0, n_compared = 0;
  emb_bus uut (.clock, .reset_n, .mode_strap, .sleep, .exec_from_external, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .req_valid, .req, .req_ready, .resp_done,
    .resp_rdata, .pins_are_bus, .ad_in, .ad_out, .ad_oe, .upper_addr_out, .upper_addr_oe,
    .address_latch_strobe(ale), .output_enable_n(oe_n), .chip_enable_n(ce_n),
    .write_high_strobe_n(hi_n), .write_low_strobe_n(lo_n), .upper_byte_select_n(usel_n),
    .lower_byte_select_n(lsel_n), .byte_address_lsb(ba));
  emb_ext_mem mem (.clock, .ad_out, .ad_oe, .upper_addr_out, .ale, .oe_n, .ce_n, .hi_n,
    .lo_n, .usel_n, .lsel_n, .ba, .ad_in, .wdata, .wstb, .nwr);
  initial forever #25 clock = ~clock;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [15:0] mw(input logic [20:0] a);
    return a[16:1] ^ {12'h000, a[20:17]} ^ 16'h5a3c;
  endfunction
  // strobes and selects {high, low, upper, lower, byte address} for an odd/even write
  function automatic logic [4:0] es(input int m, input int b);
    if (m >= 2) return 5'h09;
    if (m == 1) return b ? 5'h0b : 5'h0c;
    return b ? 5'h09 : 5'h10;
  endfunction
  task automatic do_reset(input emb_pkg::emb_mode_t m);
    reset_n <= 1'b0;
    mode_strap <= m;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    check({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // n counts edges from the taking edge to the one that sees the finish pulse
  task automatic acc(input emb_pkg::emb_kind_t k, input logic [20:0] a,
      input logic [7:0] t, output int n);
    req_valid <= 1'b1;
    req <= '{k, a, t};
    do @(posedge clock); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (resp_done !== 1'b1 && n < 40);
  endtask
  initial begin
    int n;
    logic [20:0] a;
    logic [7:0] t, h, c;
    void'($urandom(32'hd57a2fee));
    do_reset(emb_pkg::MODE_MICROPROCESSOR);
    check(pins_are_bus, 1'b1);
    rdc(4'h0, 8'h00);
    wr(4'h0, 8'hff);
    rdc(4'h0, 8'hb3);
    rdc(4'h9, 8'h00);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 21'h1fffff : 21'($urandom);
      acc(emb_pkg::ACC_FETCH, a, 8'h00, n);
      check(resp_rdata, mw(a));
      check(n, 8);
    end
    for (int w = 0; w < 4; w++) begin
      wr(4'h0, {2'h0, 2'(w), 4'h0});
      a = 21'($urandom);
      acc(emb_pkg::ACC_TABLE_READ, a, 8'h00, n);
      check(resp_rdata, mw(a));
      check(n, 20 - 4 * w);
    end
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, {4'h3, 2'h0, 2'(m)});
      a = {20'($urandom), 1'b0};
      for (int b = 0; b < 2; b++) begin
        t = 8'($urandom);
        a[0] = 1'(b);
        c = nwr;
        acc(emb_pkg::ACC_TABLE_WRITE, a, t, n);
        if (m >= 2 && b == 0) begin
          check(nwr, c);
          h = t;
        end else begin
          check(wdata, m >= 2 ? {t, h} : {t, t});
          check(wstb, es(m, b));
        end
      end
    end
    $display("test external mode done");
    do_reset(emb_pkg::MODE_MICROCONTROLLER);
    wr(4'h0, 8'h33);
    rdc(4'h0, 8'h00);
    rdc(4'h1, 8'h13);
    check({pins_are_bus, req_ready}, 2'h0);
    $display("test internal mode done");
    do_reset(emb_pkg::MODE_EXTENDED);
    check(pins_are_bus, 1'b1);
    exec_from_external <= 1'b1;
    wr(4'h0, 8'h80);
    repeat (3) @(posedge clock);
    check(pins_are_bus, 1'b1);
    exec_from_external <= 1'b0;
    repeat (3) @(posedge clock);
    check(pins_are_bus, 1'b0);
    acc(emb_pkg::ACC_FETCH, 21'h0abcd, 8'h00, n);
    check(resp_rdata, mw(21'h0abcd));
    repeat (3) @(posedge clock);
    check(pins_are_bus, 1'b0);
    wr(4'h0, 8'h00);
    repeat (3) @(posedge clock);
    check(pins_are_bus, 1'b1);
    $display("test mixed mode done");
    do_reset(emb_pkg::MODE_BOOT_BLOCK);
    sleep <= 1'b1;
    repeat (3) @(posedge clock);
    check({req_ready, ce_n}, 2'h1);
    sleep <= 1'b0;
    acc(emb_pkg::ACC_TABLE_READ, 21'h000002, 8'h00, n);
    check(resp_rdata, mw(21'h000002));
    $display("test sleep done");
    end_of_test;
  end
  // about 310 cycles are needed; the limit allows some six times that
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
